/* File: csvc_defs.svh */
`ifndef CSVC_DEFS_SVH
`define CSVC_DEFS_SVH

// Volume address width and command opcode width
`define CSVC_VOL_W          4
`define CSVC_OP_W           8
// Select-high hold time in ns and its cycle count at 100 ns per cycle
`define CSVC_CLK_PERIOD_NS  100
`define CSVC_HOLD_NS        100
`define CSVC_HOLD_CYC       ((`CSVC_HOLD_NS + `CSVC_CLK_PERIOD_NS - 1) / `CSVC_CLK_PERIOD_NS)
// Reset value of the volume register
`define CSVC_VOL_RST        4'h0

`endif

/* File: csvc_pkg.sv */
package csvc_pkg;
  `include "csvc_defs.svh"

  // Command strobe from the host command decoder
  typedef struct packed {
    logic                    valid;    // One-cycle command strobe
    logic                    appoint;  // Volume appoint command
    logic                    pick;     // Volume pick command
    logic                    term;     // Appoint as terminator for picked volume
    logic [`CSVC_VOL_W-1:0]  vol;      // Volume operand
  } csvc_cmd_t;

  // Per-target state
  typedef enum logic [1:0] {
    CSVC_UNAPPOINTED,
    CSVC_DESELECTED,
    CSVC_SELECTED
  } csvc_state_t;
endpackage

/* File: csvc_chain.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csvc_defs.svh"

module csvc_chain #(
  parameter int unsigned HOLD_CYC = `CSVC_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Host select line and chain pins
  input  wire logic                   sel_n,
  input  wire logic                   chain_enable_in_i,
  output logic                        chain_enable_out_o,
  output logic                        chain_enable_out_oe_n,
  // Command strobe from the decoder
  input  wire csvc_pkg::csvc_cmd_t    cmd,
  // Status to the logical units
  output logic                        cmd_accept,
  output logic                        logical_unit_active,
  output logic                        logical_unit_revert,
  output logic                        appointed,
  output logic [`CSVC_VOL_W-1:0]      volume
);
  import csvc_pkg::*;

  // Hold limit cut to the counter width on purpose
  localparam logic [15:0] HOLD_LIM = HOLD_CYC[15:0];

  // State decode shared by the accept gate, chain output and status
  function automatic logic is_unappointed(input csvc_state_t s);
    return (s == CSVC_UNAPPOINTED);
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------

  // Three-stage synchronisers; stage one is read only by stage two
  logic [2:0] sel_sync_q, sel_sync_d;
  logic [2:0] en_sync_q, en_sync_d;
  logic       sel_lo_q, sel_lo_d;
  logic       en_hi_q, en_hi_d;

  // A level counts only once stages two and three agree
  always_comb begin
    sel_sync_d = {sel_sync_q[1:0], ~sel_n};
    en_sync_d  = {en_sync_q[1:0], chain_enable_in_i};
    sel_lo_d   = sel_lo_q;
    en_hi_d    = en_hi_q;
    if (sel_sync_q[1] == sel_sync_q[2]) begin
      sel_lo_d = sel_sync_q[2];
    end
    if (en_sync_q[1] == en_sync_q[2]) begin
      en_hi_d = en_sync_q[2];
    end
  end

  // Chain input resets high, standing for the internal pull-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_sync_q <= 3'h0;
      en_sync_q  <= 3'h7;
      sel_lo_q   <= 1'b0;
      en_hi_q    <= 1'b1;
    end else begin
      sel_sync_q <= sel_sync_d;
      en_sync_q  <= en_sync_d;
      sel_lo_q   <= sel_lo_d;
      en_hi_q    <= en_hi_d;
    end
  end

  // --------------------------------------------------------------------
  // Command gate
  // --------------------------------------------------------------------

  // Target state, volume register and hold counter
  csvc_state_t             state_q, state_d;
  logic [`CSVC_VOL_W-1:0]  vol_q, vol_d;
  logic                    term_q, term_d;
  logic [15:0]             hold_q, hold_d;
  logic                    revert_q, revert_d;
  logic                    accept;

  // Before appointment the chain gates commands; afterwards it is ignored
  always_comb begin
    if (is_unappointed(state_q)) begin
      accept = sel_lo_q && en_hi_q;
    end else begin
      accept = sel_lo_q;
    end
  end

  // --------------------------------------------------------------------
  // Select-high hold counter
  // --------------------------------------------------------------------

  // Counts while select high; saturates so the revert fires only once
  always_comb begin
    hold_d   = hold_q;
    revert_d = 1'b0;
    if (sel_lo_q) begin
      hold_d = 16'h0000;
    end else if (hold_q < HOLD_LIM) begin
      hold_d = hold_q + 16'h0001;
      if (hold_d == HOLD_LIM) begin
        revert_d = 1'b1;
      end
    end
  end

  // Reset to the limit, so no false revert follows power-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q   <= HOLD_LIM;
      revert_q <= 1'b0;
    end else begin
      hold_q   <= hold_d;
      revert_q <= revert_d;
    end
  end

  // --------------------------------------------------------------------
  // Target state and volume register
  // --------------------------------------------------------------------

  // Appoint once, then picks decide selection
  always_comb begin
    state_d  = state_q;
    vol_d    = vol_q;
    term_d   = term_q;
    if (cmd.valid && accept) begin
      if (cmd.appoint && is_unappointed(state_q)) begin
        vol_d   = cmd.vol;
        state_d = CSVC_DESELECTED;
      end else if (cmd.pick && !is_unappointed(state_q)) begin
        // Match selects; a pick of another volume always deselects, and its term flag sets the terminator
        if (cmd.vol == vol_q) begin
          state_d = CSVC_SELECTED;
          term_d  = 1'b0;
        end else begin
          state_d = CSVC_DESELECTED;
          term_d  = cmd.term;
        end
      end
    end
    // Select high past hold time returns to the state before selection
    if (revert_d && state_q == CSVC_SELECTED) begin
      state_d = CSVC_DESELECTED;
    end
  end

  // Volume survives everything but reset, the stand-in for a power cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= CSVC_UNAPPOINTED;
      vol_q    <= `CSVC_VOL_RST;
      term_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      vol_q    <= vol_d;
      term_q   <= term_d;
    end
  end

  // --------------------------------------------------------------------
  // Chain output pin
  // --------------------------------------------------------------------

  // Low only while selected and unappointed; value stays 0
  // Released pin relies on the next package's pull-up, so no high drive
  always_comb begin
    chain_enable_out_o    = 1'b0;
    chain_enable_out_oe_n = ~(sel_lo_q && is_unappointed(state_q));
  end

  // --------------------------------------------------------------------
  // Status outputs
  // --------------------------------------------------------------------

  // Logical units active when selected or acting as terminator
  assign cmd_accept          = accept;
  assign logical_unit_active = (state_q == CSVC_SELECTED) || term_q;
  assign logical_unit_revert = revert_q;
  assign appointed           = !is_unappointed(state_q);
  assign volume              = vol_q;

  // Limitation: one target per instance; sharing is done at the pins

endmodule // csvc_chain
`default_nettype wire

/* File: csvc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module csvc_host_model (
  // Host side pins
  input  wire logic           clk,
  output var logic            sel_n,
  output var csvc_pkg::csvc_cmd_t cmd
);
  import csvc_pkg::*;
  initial begin
    sel_n = 1'b1;
    cmd = '0;
  end
  // Own select pulled alone, one per target
  task automatic select(input logic lvl);
    @(negedge clk) sel_n = lvl;
  endtask
  // One-cycle strobe, pick before work, terminator flag
  task automatic issue(input logic ap, pk, tm, input logic [3:0] v);
    @(negedge clk) cmd = '{1'b1, ap, pk, tm, v};
    @(negedge clk) cmd = '0;
  endtask
endmodule // csvc_host_model
`default_nettype wire

/* File: csvc_chain_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module csvc_chain_assertions #(
  parameter int unsigned HOLD_CYC = 1
) (
  // Design ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic chain_enable_in_i,
  input wire logic chain_enable_out_o,
  input wire logic chain_enable_out_oe_n,
  input wire csvc_pkg::csvc_cmd_t cmd,
  input wire logic cmd_accept,
  input wire logic logical_unit_active,
  input wire logic logical_unit_revert,
  input wire logic appointed,
  input wire logic [3:0] volume
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pin_low: assert property (!chain_enable_out_o)
    else $error("out pin not low");
  a_drive_low: assert property ((!sel_n)[*5] ##0 !appointed |-> !chain_enable_out_oe_n)
    else $error("out not driven");
  a_float_appt: assert property (appointed |-> chain_enable_out_oe_n)
    else $error("out driven");
  a_float_idle: assert property (sel_n[*5] |-> chain_enable_out_oe_n)
    else $error("out driven idle");
  a_chain_block: assert property ((!chain_enable_in_i)[*5] ##0 !appointed |-> !cmd_accept)
    else $error("accept with chain low");
  a_appoint_take: assert property (cmd.valid && cmd.appoint && cmd_accept && !appointed
    |=> appointed && volume == $past(cmd.vol))
    else $error("appoint lost");
  a_vol_hold: assert property (appointed |=> $stable(volume))
    else $error("volume moved");
  a_pick_match: assert property (cmd.valid && cmd.pick && cmd_accept && appointed
    && cmd.vol == volume |=> logical_unit_active)
    else $error("pick missed");
  a_idle_unit: assert property (!appointed |-> !logical_unit_active)
    else $error("unit active unappointed");
  a_revert_cause: assert property (logical_unit_revert |-> $past(sel_n, 3))
    else $error("revert without select high");
  c_pick: cover property (appointed && logical_unit_active);
  c_revert: cover property (logical_unit_revert);
  c_drive: cover property (!chain_enable_out_oe_n);
endmodule // csvc_chain_assertions
bind csvc_chain csvc_chain_assertions #(.HOLD_CYC(HOLD_CYC)) u_chk (.*);
`default_nettype wire

/* File: csvc_chain_test.sv */
`timescale 1ns/1ps
`default_nettype none
module csvc_chain_test;
  import csvc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, chain_in = 1'b1, sel_n;
  logic oe_n, out_val, accept, active, revert, appt;
  logic [3:0] vol;
  csvc_cmd_t cmd;
  int failures = 0, compares = 0;
  // Terminator flag in bit 5, expected activity in bit 4, pick operand below
  logic [5:0] rows [5] = '{6'h03, 6'h15, 6'h33, 6'h00, 6'h15};
  always #50 clk = ~clk;
  csvc_host_model host (.clk(clk), .sel_n(sel_n), .cmd(cmd));
  csvc_chain dut (.clk(clk), .rst_n(rst_n), .sel_n(sel_n), .chain_enable_in_i(chain_in),
    .chain_enable_out_o(out_val), .chain_enable_out_oe_n(oe_n), .cmd(cmd), .cmd_accept(accept),
    .logical_unit_active(active), .logical_unit_revert(revert), .appointed(appt), .volume(vol));
  task automatic chk(input logic [3:0] got, exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Chain held low first, so the appoint must be ignored
  initial begin
    repeat (8) @(negedge clk);
    chk(oe_n, 1);
    rst_n = 1'b1;
    chain_in = 1'b0;
    host.select(1'b0);
    repeat (5) @(negedge clk);
    chk(accept, 0);
    chk(oe_n, 0);
    chk(out_val, 0);
    host.issue(1, 0, 0, 4'h5);
    chk(appt, 0);
    chain_in = 1'b1;
    repeat (5) @(negedge clk);
    chk(accept, 1);
    host.issue(1, 0, 0, 4'h5);
    host.issue(1, 0, 0, 4'h9);
    chain_in = 1'b0;
    chk(vol, 4'h5);
    chk(oe_n, 1);
    foreach (rows[i]) begin
      host.issue(0, 1, rows[i][5], rows[i][3:0]);
      chk(active, rows[i][4]);
    end
    host.select(1'b1);
    for (int n = 0; n < 10 && revert !== 1'b1; n++) @(negedge clk);
    chk(revert, 1);
    @(negedge clk);
    chk(active, 0);
    print_verdict();
  end
endmodule // csvc_chain_test
`default_nettype wire
